// ===== design/pwm_time_base_control.sv
// PWM master time base, sync, special event and register protection
//
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
module pwm_time_base_control
	import pwm_tb_pkg::*;
#(
	parameter int TB_WIDTH = 16
)(
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        RESET,
	// AXI4-Lite write address
	input  wire logic [7:0]  AWADDR,
	input  wire logic        AWVALID,
	output logic             AWREADY,
	// AXI4-Lite write data
	input  wire logic [31:0] WDATA,
	input  wire logic [3:0]  WSTRB,
	input  wire logic        WVALID,
	output logic             WREADY,
	// AXI4-Lite write response
	output logic [1:0]       BRESP,
	output logic             BVALID,
	input  wire logic        BREADY,
	// AXI4-Lite read
	input  wire logic [7:0]  ARADDR,
	input  wire logic        ARVALID,
	output logic             ARREADY,
	output logic [31:0]      RDATA,
	output logic [1:0]       RRESP,
	output logic             RVALID,
	input  wire logic        RREADY,
	// Device state and pins
	input  wire logic        CPU_IDLE,
	input  wire logic        REGISTER_LOCK_CONFIG,
	input  wire logic        CLASS_B_FAULT_INPUT,
	input  wire logic        EXT_SYNC_IN_PIN,
	output logic             EXT_SYNC_OUT_PIN,
	output logic             EXT_SYNC_OUT_OE,
	// Time base, special event and fault outputs
	output logic [TB_WIDTH-1:0] TIME_BASE_COUNT,
	output logic             SPECIAL_EVENT_TRIGGER,
	output logic             SPECIAL_EVENT_IRQ,
	output logic             CLASS_B_FAULT_OWNED,
	output logic             CLASS_B_FAULT_ACTIVE
);
	import pwm_tb_pkg::*;
	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [15:0]         tbcon_reg;
	logic [2:0]          clkdiv_reg;
	logic [15:0]         period_reg;
	logic [15:0]         active_period_reg;
	logic [15:0]         secmp_reg;
	logic [15:0]         outctl_reg;
	logic [15:0]         fltctl_reg;
	logic [1:0]          key_stage_reg;
	logic [TB_WIDTH-1:0] count_reg;
	logic [5:0]          prescale_reg;
	logic [3:0]          post_reg;
	logic                fault_latch_reg, sync_in_prev_reg, trig_reg, sync_pulse_reg;
	// Bus state
	logic [7:0]          awaddr_reg;
	logic [31:0]         wdata_reg, rdata_reg;
	logic [3:0]          wstrb_reg;
	logic [1:0]          bresp_reg, rresp_reg;
	logic                aw_have_reg, w_have_reg, bvalid_reg, rvalid_reg;
	logic [15:0]         wr_val;
	logic [5:0]          div_max;
	logic                module_on, wr_fire, rd_fire, wr_hit_known, unlocked, prot_ok;
	logic                tick, sync_level, sync_edge, period_end, run, se_match;
	assign module_on = tbcon_reg[BIT_MODULE_ON];

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	assign AWREADY = !aw_have_reg && !bvalid_reg;
	assign WREADY  = !w_have_reg && !bvalid_reg;
	assign ARREADY = !rvalid_reg;
	assign BVALID  = bvalid_reg;
	assign BRESP   = bresp_reg;
	assign RVALID  = rvalid_reg;
	assign RDATA   = rdata_reg;
	assign RRESP   = rresp_reg;

	assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
	assign rd_fire = ARVALID && !rvalid_reg;
	// Registers are at most 16 bits wide; the low two lanes carry them
	assign wr_val  = {wstrb_reg[1] ? wdata_reg[15:8] : 8'h00,
		wstrb_reg[0] ? wdata_reg[7:0] : 8'h00};

	always_comb
	begin
		unique case (awaddr_reg)
			OFF_TBCON, OFF_CLKDIV, OFF_PERIOD, OFF_SECMP, OFF_KEY,
			OFF_OUTCTL, OFF_FLTCTL, OFF_STATUS: wr_hit_known = 1'b1;
			default: wr_hit_known = 1'b0;
		endcase
	end

	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			aw_have_reg <= 1'b0;
			w_have_reg  <= 1'b0;
			awaddr_reg  <= 8'h00;
			wdata_reg   <= 32'h00000000;
			wstrb_reg   <= 4'h0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= RESP_OKAY;
		end
		else
		begin
			if (AWVALID && AWREADY)
			begin
				aw_have_reg <= 1'b1;
				awaddr_reg  <= AWADDR;
			end
			if (WVALID && WREADY)
			begin
				w_have_reg <= 1'b1;
				wdata_reg  <= WDATA;
				wstrb_reg  <= WSTRB;
			end
			if (wr_fire)
			begin
				aw_have_reg <= 1'b0;
				w_have_reg  <= 1'b0;
				bvalid_reg  <= 1'b1;
				bresp_reg   <= wr_hit_known ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bvalid_reg && BREADY)
				bvalid_reg <= 1'b0;
		end
	end

	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h00000000;
			rresp_reg  <= RESP_OKAY;
		end
		else if (rd_fire)
		begin
			rvalid_reg <= 1'b1;
			rresp_reg  <= RESP_OKAY;
			unique case (ARADDR)
				OFF_TBCON:  rdata_reg <= {16'h0000, tbcon_reg & 16'hbfff};
				OFF_CLKDIV: rdata_reg <= {29'h0, clkdiv_reg};
				OFF_PERIOD: rdata_reg <= {16'h0000, period_reg};
				OFF_SECMP:  rdata_reg <= {16'h0000, secmp_reg};
				OFF_KEY:    rdata_reg <= 32'h00000000;
				OFF_OUTCTL: rdata_reg <= {16'h0000, outctl_reg};
				OFF_FLTCTL: rdata_reg <= {16'h0000, fltctl_reg};
				OFF_STATUS: rdata_reg <= {29'h0, unlocked, fault_latch_reg,
					CLASS_B_FAULT_INPUT};
				default:
				begin
					rdata_reg <= 32'h00000000;
					rresp_reg <= RESP_SLVERR;
				end
			endcase
		end
		else if (rvalid_reg && RREADY)
			rvalid_reg <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Key unlock sequence
	// ----------------------------------------------------------------
	assign unlocked = (key_stage_reg == 2'd2);
	assign prot_ok  = !REGISTER_LOCK_CONFIG || unlocked;

	always_ff @(posedge CLK)
	begin
		if (RESET)
			key_stage_reg <= 2'd0;
		// any register access ends the sequence unless it is the next key
		else if (wr_fire && awaddr_reg == OFF_KEY)
		begin
			if (key_stage_reg == 2'd0 && wr_val == KEY_FIRST)
				key_stage_reg <= 2'd1;
			else if (key_stage_reg == 2'd1 && wr_val == KEY_SECOND)
				key_stage_reg <= 2'd2;
			else
				key_stage_reg <= 2'd0;
		end
		else if (wr_fire || rd_fire)
			key_stage_reg <= 2'd0;
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			tbcon_reg  <= RST_TBCON;
			clkdiv_reg <= RST_CLKDIV;
			period_reg <= RST_PERIOD;
			secmp_reg  <= RST_SECMP;
			outctl_reg <= RST_OUTCTL;
			fltctl_reg <= RST_FLTCTL;
		end
		else
		begin
			if (wr_fire)
			begin
				unique case (awaddr_reg)
					OFF_TBCON:
						tbcon_reg <= {wr_val[15], 1'b0, wr_val[13],
							tbcon_reg[BIT_SE_PENDING] & wr_val[12],
							wr_val[11:0]};
					OFF_CLKDIV: clkdiv_reg <= wr_val[2:0];
					OFF_PERIOD: period_reg <= wr_val;
					OFF_SECMP:  secmp_reg  <= wr_val;
					OFF_OUTCTL: if (prot_ok) outctl_reg <= wr_val;
					// mode bits take any value whatever the pin level
					OFF_FLTCTL: if (prot_ok) fltctl_reg <= wr_val;
					default: ;
				endcase
			end
			// hardware set wins over a software clear
			if (trig_reg && tbcon_reg[BIT_SE_IRQ_EN])
				tbcon_reg[BIT_SE_PENDING] <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Class B fault
	// ----------------------------------------------------------------
	// owned through reset, latched mode from reset
	assign CLASS_B_FAULT_OWNED  = 1'b1;
	assign CLASS_B_FAULT_ACTIVE = fault_latch_reg;

	always_ff @(posedge CLK)
	begin
		if (RESET)
			fault_latch_reg <= 1'b1;
		else if (fltctl_reg[1:0] == FLT_MODE_LATCHED && CLASS_B_FAULT_INPUT)
			fault_latch_reg <= 1'b1;
		// Clear needs the pin low; a write while still high is lost
		else if (wr_fire && awaddr_reg == OFF_STATUS && wr_val[BIT_FLT_LATCHED])
			fault_latch_reg <= 1'b0;
		else if (fltctl_reg[1:0] != FLT_MODE_LATCHED)
			fault_latch_reg <= CLASS_B_FAULT_INPUT;
	end

	// ----------------------------------------------------------------
	// Prescaler and time base
	// ----------------------------------------------------------------
	// divide by two to the code; reserved code holds the clock
	assign div_max = 6'((7'd1 << clkdiv_reg) - 7'd1);
	// halt in idle; a held prescaler must not tick
	assign run     = module_on && !(CPU_IDLE && tbcon_reg[BIT_HALT_IDLE]);
	assign tick    = run && (clkdiv_reg != CLKDIV_RESERVED) && (prescale_reg == div_max);
	always_ff @(posedge CLK)
	begin
		if (RESET || !run || tick)
			prescale_reg <= 6'd0;
		else
			prescale_reg <= prescale_reg + 6'd1;
	end

	assign sync_level = EXT_SYNC_IN_PIN ^ tbcon_reg[BIT_SYNC_INV];
	// only the pin source restarts the count
	assign sync_edge  = tbcon_reg[BIT_EXT_SYNC_EN] && sync_level && !sync_in_prev_reg
		&& tbcon_reg[POS_SYNC_SRC+:3] == SYNC_SRC_PIN;
	// period closes at the active period count
	assign period_end = tick && (count_reg >= TB_WIDTH'(active_period_reg));
	assign se_match   = tick && (count_reg == TB_WIDTH'(secmp_reg));

	always_ff @(posedge CLK)
	begin
		if (RESET || !module_on)
			count_reg <= '0;
		else if (run && (sync_edge || period_end))
			count_reg <= '0;
		else if (tick)
			count_reg <= count_reg + 1'b1;
	end

	always_ff @(posedge CLK)
	begin
		if (RESET)
			active_period_reg <= RST_PERIOD;
		else if (tbcon_reg[BIT_IMM_UPDATE] || period_end || !module_on)
			active_period_reg <= period_reg;
	end

	// ----------------------------------------------------------------
	// Special event postscaler and sync output
	// ----------------------------------------------------------------
	always_ff @(posedge CLK)
	begin
		if (RESET || !module_on)
		begin
			post_reg <= 4'h0;
			trig_reg <= 1'b0;
		end
		else if (se_match)
		begin
			trig_reg <= (post_reg == tbcon_reg[POS_POSTSCALE+:4]);
			post_reg <= (post_reg == tbcon_reg[POS_POSTSCALE+:4]) ? 4'h0 : post_reg + 4'h1;
		end
		else
			trig_reg <= 1'b0;
	end
	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			sync_in_prev_reg <= 1'b0;
			sync_pulse_reg   <= 1'b0;
		end
		else
		begin
			sync_in_prev_reg <= sync_level;
			sync_pulse_reg   <= run && (period_end || sync_edge);
		end
	end

	assign SPECIAL_EVENT_TRIGGER = trig_reg;
	assign SPECIAL_EVENT_IRQ     = tbcon_reg[BIT_SE_PENDING] && tbcon_reg[BIT_SE_IRQ_EN];
	assign TIME_BASE_COUNT       = count_reg;
	assign EXT_SYNC_OUT_OE       = tbcon_reg[BIT_SYNC_OUT_EN];
	assign EXT_SYNC_OUT_PIN      = tbcon_reg[BIT_SYNC_OUT_EN]
		&& (sync_pulse_reg ^ tbcon_reg[BIT_SYNC_INV]);
endmodule : pwm_time_base_control

// ===== include/pwm_tb_pkg.sv
// Constants for the PWM master time-base control block
package pwm_tb_pkg;
	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_TBCON   = 8'h00;
	localparam logic [7:0] OFF_CLKDIV  = 8'h04;
	localparam logic [7:0] OFF_PERIOD  = 8'h08;
	localparam logic [7:0] OFF_SECMP   = 8'h0c;
	localparam logic [7:0] OFF_KEY     = 8'h10;
	localparam logic [7:0] OFF_OUTCTL  = 8'h14;
	localparam logic [7:0] OFF_FLTCTL  = 8'h18;
	localparam logic [7:0] OFF_STATUS  = 8'h1c;
	// ----------------------------------------------------------------
	// Field positions in the time-base control register; BIT_FLT_LATCHED is the status clear bit
	// ----------------------------------------------------------------
	localparam int BIT_MODULE_ON   = 15;
	localparam int BIT_HALT_IDLE   = 13;
	localparam int BIT_SE_PENDING  = 12;
	localparam int BIT_SE_IRQ_EN   = 11;
	localparam int BIT_IMM_UPDATE  = 10;
	localparam int BIT_SYNC_INV    = 9;
	localparam int BIT_SYNC_OUT_EN = 8;
	localparam int BIT_EXT_SYNC_EN = 7;
	localparam int POS_SYNC_SRC    = 4;
	localparam int POS_POSTSCALE   = 0;
	localparam int BIT_FLT_LATCHED = 0;
	// ----------------------------------------------------------------
	// Values after reset and codes
	// ----------------------------------------------------------------
	localparam logic [15:0] RST_TBCON  = 16'h0000;
	localparam logic [2:0]  RST_CLKDIV = 3'h0;
	localparam logic [15:0] RST_PERIOD = 16'hfff8;
	localparam logic [15:0] RST_SECMP  = 16'h0000;
	localparam logic [15:0] RST_OUTCTL = 16'h0000;
	// Fault mode field reset: latched mode on the class B input
	localparam logic [15:0] RST_FLTCTL = 16'h0000;
	localparam logic [1:0]  FLT_MODE_LATCHED = 2'h0;
	localparam logic [15:0] KEY_FIRST  = 16'habcd;
	localparam logic [15:0] KEY_SECOND = 16'h4321;
	localparam logic [2:0]  SYNC_SRC_PIN = 3'h0;
	localparam logic [2:0]  CLKDIV_RESERVED = 3'h7;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage : pwm_tb_pkg

// ===== tb/pwm_tbc_props.sv
// Port-level checks for the time-base control block
`timescale 1ns/100ps
module pwm_tbc_props
#(
	parameter int TB_WIDTH = 16
)(
	// Clock and reset
	input wire logic                CLK,
	input wire logic                RESET,
	// Bus handshakes
	input wire logic                AWVALID,
	input wire logic                AWREADY,
	input wire logic                WVALID,
	input wire logic                WREADY,
	input wire logic [1:0]          BRESP,
	input wire logic                BVALID,
	input wire logic                BREADY,
	input wire logic                ARVALID,
	input wire logic                ARREADY,
	input wire logic [31:0]         RDATA,
	input wire logic                RVALID,
	input wire logic                RREADY,
	// Time base and fault
	input wire logic [TB_WIDTH-1:0] TIME_BASE_COUNT,
	input wire logic                CLASS_B_FAULT_OWNED,
	input wire logic                CLASS_B_FAULT_ACTIVE
);
	// ----------------------------------------------------------------
	// Handshake and reset relations
	// ----------------------------------------------------------------
	sequence s_write_taken;
		AWVALID && AWREADY && WVALID && WREADY;
	endsequence
	sequence s_read_taken;
		ARVALID && ARREADY;
	endsequence
	AST_B_ANSWER: assert property (@(posedge CLK) disable iff (RESET) s_write_taken |-> ##2 BVALID)
		else $error("write answer late");
	AST_B_STANDS: assert property (@(posedge CLK) disable iff (RESET)
		BVALID && !BREADY |=> BVALID && $stable(BRESP)) else $error("write answer dropped");
	AST_B_BLOCKS: assert property (@(posedge CLK) disable iff (RESET)
		BVALID |-> !AWREADY && !WREADY) else $error("write taken while answer pending");
	AST_R_ANSWER: assert property (@(posedge CLK) disable iff (RESET) s_read_taken |=> RVALID)
		else $error("read answer late");
	AST_R_STANDS: assert property (@(posedge CLK) disable iff (RESET)
		RVALID && !RREADY |=> RVALID && $stable(RDATA)) else $error("read answer dropped");
	AST_AR_GATE: assert property (@(posedge CLK) disable iff (RESET) ARREADY == !RVALID)
		else $error("read ready wrong");
	// Reset must not be a disable here, it is the cause
	AST_FLT_RESET: assert property (@(posedge CLK) RESET |=> CLASS_B_FAULT_ACTIVE
		&& TIME_BASE_COUNT == {TB_WIDTH{1'b0}}) else $error("fault not latched at reset");
	AST_FLT_OWNED: assert property (@(posedge CLK) CLASS_B_FAULT_OWNED)
		else $error("fault input not owned");
	AST_TB_STEP: assert property (@(posedge CLK) disable iff (RESET)
		TIME_BASE_COUNT == {TB_WIDTH{1'b0}} || TIME_BASE_COUNT == $past(TIME_BASE_COUNT)
		|| TIME_BASE_COUNT == $past(TIME_BASE_COUNT) + 1'b1) else $error("count jumped");
endmodule : pwm_tbc_props

bind pwm_time_base_control pwm_tbc_props #(.TB_WIDTH(TB_WIDTH)) u_props (
	.CLK(CLK), .RESET(RESET), .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID),
	.WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID),
	.ARREADY(ARREADY), .RDATA(RDATA), .RVALID(RVALID), .RREADY(RREADY),
	.TIME_BASE_COUNT(TIME_BASE_COUNT), .CLASS_B_FAULT_OWNED(CLASS_B_FAULT_OWNED),
	.CLASS_B_FAULT_ACTIVE(CLASS_B_FAULT_ACTIVE));

// ===== tb/sync_partner.sv
// External sync source feeding the block's sync input
`timescale 1ns/100ps
module sync_partner
#(
	parameter int PER = 20
)(
	// Clock and control
	input  wire logic CLK,
	input  wire logic en,
	input  wire logic inv,
	// Sync line
	output logic      sync_pin
);
	int cnt_reg = 0;
	always_ff @(posedge CLK)
		cnt_reg <= (cnt_reg == PER - 1) ? 0 : cnt_reg + 1;
	always_ff @(posedge CLK)
		sync_pin <= (en && cnt_reg == 0) ? !inv : inv;
endmodule : sync_partner

// ===== tb/tb_pwm_time_base_control.sv
// Self-checking bench for the time-base control block
`timescale 1ns/100ps
module tb_pwm_time_base_control;
	import pwm_tb_pkg::*;
	logic        CLK, RESET, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
	logic        ARVALID, ARREADY, RVALID, RREADY, CPU_IDLE, REGISTER_LOCK_CONFIG;
	logic        CLASS_B_FAULT_INPUT, EXT_SYNC_IN_PIN, EXT_SYNC_OUT_PIN, EXT_SYNC_OUT_OE;
	logic        SPECIAL_EVENT_TRIGGER, SPECIAL_EVENT_IRQ, CLASS_B_FAULT_OWNED, CLASS_B_FAULT_ACTIVE;
	logic [7:0]  AWADDR, ARADDR;
	logic [31:0] WDATA, RDATA, rd;
	logic [1:0]  BRESP, RRESP, resp;
	logic [15:0] TIME_BASE_COUNT, mx;
	logic        sync_en, sync_inv;
	int          err_count, cmp_count, cycles, n;

	pwm_time_base_control dut (
		.CLK(CLK), .RESET(RESET), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
		.WDATA(WDATA), .WSTRB(4'h3), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
		.BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
		.ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
		.CPU_IDLE(CPU_IDLE), .REGISTER_LOCK_CONFIG(REGISTER_LOCK_CONFIG),
		.CLASS_B_FAULT_INPUT(CLASS_B_FAULT_INPUT), .EXT_SYNC_IN_PIN(EXT_SYNC_IN_PIN),
		.EXT_SYNC_OUT_PIN(EXT_SYNC_OUT_PIN), .EXT_SYNC_OUT_OE(EXT_SYNC_OUT_OE),
		.TIME_BASE_COUNT(TIME_BASE_COUNT), .SPECIAL_EVENT_TRIGGER(SPECIAL_EVENT_TRIGGER),
		.SPECIAL_EVENT_IRQ(SPECIAL_EVENT_IRQ), .CLASS_B_FAULT_OWNED(CLASS_B_FAULT_OWNED),
		.CLASS_B_FAULT_ACTIVE(CLASS_B_FAULT_ACTIVE));
	sync_partner u_sync (.CLK(CLK), .en(sync_en), .inv(sync_inv), .sync_pin(EXT_SYNC_IN_PIN));

	// ----------------------------------------------------------------
	// Clock, timeout and shared tasks
	// ----------------------------------------------------------------
	initial
	begin
		CLK = 1'b0;
		forever #10 CLK = ~CLK;
	end
	// Whole run needs a few thousand cycles
	always @(posedge CLK)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			err_count++;
			tally_and_finish();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge CLK);
		AWADDR <= a;
		WDATA <= {16'h0000, d};
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		do
		begin
			@(posedge CLK);
			if (!aw && AWREADY === 1'b1)
			begin
				aw = 1'b1;
				AWVALID <= 1'b0;
			end
			if (!w && WREADY === 1'b1)
			begin
				w = 1'b1;
				WVALID <= 1'b0;
			end
		end while (!(aw && w));
		do @(posedge CLK); while (BVALID !== 1'b1);
		resp = BRESP;
		BREADY <= 1'b0;
	endtask : wr
	task automatic rd_reg(input logic [7:0] a);
		@(posedge CLK);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		do @(posedge CLK); while (ARREADY !== 1'b1);
		ARVALID <= 1'b0;
		do @(posedge CLK); while (RVALID !== 1'b1);
		rd = RDATA;
		resp = RRESP;
		RREADY <= 1'b0;
	endtask : rd_reg
	task automatic unlock();
		wr(OFF_KEY, KEY_FIRST);
		wr(OFF_KEY, KEY_SECOND);
	endtask : unlock
	task automatic gap(input logic [15:0] ctl, input logic [2:0] div, input int exp);
		wr(OFF_TBCON, 16'h0000);
		wr(OFF_CLKDIV, {13'h0000, div});
		wr(OFF_TBCON, ctl);
		do @(posedge CLK); while (SPECIAL_EVENT_TRIGGER !== 1'b1);
		n = 0;
		do
		begin
			@(posedge CLK);
			n++;
		end while (SPECIAL_EVENT_TRIGGER !== 1'b1);
		check(32'(n), 32'(exp));
	endtask : gap

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rd_reg(OFF_TBCON);
		check(rd, {16'h0000, RST_TBCON});
		rd_reg(OFF_PERIOD);
		check(rd, {16'h0000, RST_PERIOD});
		rd_reg(OFF_SECMP);
		check(rd, {16'h0000, RST_SECMP});
		rd_reg(OFF_FLTCTL);
		check({30'h0, rd[1:0]}, {30'h0, FLT_MODE_LATCHED});
		wr(OFF_TBCON, 16'h4000);
		check({30'h0, resp}, {30'h0, RESP_OKAY});
		rd_reg(OFF_TBCON);
		check(rd, 32'h0000_0000);
		wr(OFF_CLKDIV, 16'hffff);
		rd_reg(OFF_CLKDIV);
		check(rd, 32'h0000_0007);
		rd_reg(8'h20);
		check({30'h0, resp}, {30'h0, RESP_SLVERR});
		wr(8'h20, 16'h0000);
		check({30'h0, resp}, {30'h0, RESP_SLVERR});
		$display("test reset done");
	endtask : t_reset
	task automatic t_fault();
		check({31'h0, CLASS_B_FAULT_ACTIVE}, 32'h1);
		wr(OFF_STATUS, 16'h0001);
		rd_reg(OFF_STATUS);
		check({31'h0, rd[1]}, 32'h1);
		CLASS_B_FAULT_INPUT <= 1'b0;
		wr(OFF_STATUS, 16'h0001);
		rd_reg(OFF_STATUS);
		check({31'h0, rd[1]}, 32'h0);
		check({31'h0, CLASS_B_FAULT_ACTIVE}, 32'h0);
		$display("test fault done");
	endtask : t_fault
	task automatic t_lock();
		CLASS_B_FAULT_INPUT <= 1'b1;
		wr(OFF_OUTCTL, 16'hf000);
		rd_reg(OFF_OUTCTL);
		check(rd, 32'h0);
		unlock();
		wr(OFF_OUTCTL, 16'hf000);
		rd_reg(OFF_OUTCTL);
		check(rd, 32'hf000);
		wr(OFF_OUTCTL, 16'h0f00);
		rd_reg(OFF_OUTCTL);
		check(rd, 32'hf000);
		unlock();
		rd_reg(OFF_TBCON);
		wr(OFF_FLTCTL, 16'h0003);
		rd_reg(OFF_FLTCTL);
		check({30'h0, rd[1:0]}, 32'h0);
		wr(OFF_KEY, KEY_FIRST);
		wr(OFF_KEY, 16'h1111);
		wr(OFF_KEY, KEY_SECOND);
		wr(OFF_FLTCTL, 16'h0002);
		rd_reg(OFF_FLTCTL);
		check({30'h0, rd[1:0]}, 32'h0);
		unlock();
		wr(OFF_FLTCTL, 16'h0001);
		rd_reg(OFF_FLTCTL);
		check({30'h0, rd[1:0]}, 32'h1);
		REGISTER_LOCK_CONFIG <= 1'b0;
		wr(OFF_OUTCTL, 16'h00a5);
		rd_reg(OFF_OUTCTL);
		check(rd, 32'h00a5);
		$display("test lock done");
	endtask : t_lock
	task automatic t_time();
		wr(OFF_PERIOD, 16'h0003);
		wr(OFF_SECMP, 16'h0001);
		// One period is period plus one ticks
		for (int p = 0; p < 16; p += 5)
			gap(16'h8800 | 16'(p), 3'h0, 4 * (p + 1));
		for (int d = 1; d < 7; d++)
			gap(16'h8800, 3'(d), 4 << d);
		rd_reg(OFF_TBCON);
		check({31'h0, rd[12]}, 32'h1);
		check({31'h0, SPECIAL_EVENT_IRQ}, 32'h1);
		CPU_IDLE <= 1'b1;
		gap(16'h8800, 3'h0, 4);
		wr(OFF_TBCON, 16'ha800);
		repeat (2) @(posedge CLK);
		mx = TIME_BASE_COUNT;
		repeat (30) @(posedge CLK);
		check({16'h0, TIME_BASE_COUNT}, {16'h0, mx});
		CPU_IDLE <= 1'b0;
		$display("test time base done");
	endtask : t_time
	task automatic t_sync();
		logic [15:0] cfg [4];
		int hi;
		cfg = '{16'h8180, 16'h8380, 16'h8100, 16'h8190};
		wr(OFF_PERIOD, 16'h0040);
		for (int i = 0; i < 4; i++)
		begin
			wr(OFF_TBCON, 16'h0000);
			sync_inv <= cfg[i][9];
			sync_en <= 1'b1;
			wr(OFF_TBCON, cfg[i]);
			mx = 16'h0000;
			hi = 0;
			repeat (100)
			begin
				@(posedge CLK);
				hi += EXT_SYNC_OUT_PIN;
				if (TIME_BASE_COUNT > mx)
					mx = TIME_BASE_COUNT;
			end
			check({31'h0, mx < 16'h0020}, {31'h0, cfg[i][7] && cfg[i][6:4] == SYNC_SRC_PIN});
			check({31'h0, hi > 50}, {31'h0, cfg[i][9]});
			check({31'h0, EXT_SYNC_OUT_OE}, 32'h1);
		end
		wr(OFF_TBCON, 16'h8000);
		check({31'h0, EXT_SYNC_OUT_OE}, 32'h0);
		sync_en <= 1'b0;
		$display("test sync done");
	endtask : t_sync
	task automatic t_period();
		for (int imm = 0; imm < 2; imm++)
		begin
			wr(OFF_TBCON, 16'h0000);
			wr(OFF_PERIOD, 16'h0040);
			wr(OFF_TBCON, 16'h8000 | 16'(imm << BIT_IMM_UPDATE));
			wr(OFF_PERIOD, 16'h0003);
			mx = 16'h0000;
			repeat (2) @(posedge CLK);
			repeat (10)
			begin
				@(posedge CLK);
				if (TIME_BASE_COUNT > mx)
					mx = TIME_BASE_COUNT;
			end
			check({31'h0, mx > 16'h0003}, 32'(1 - imm));
		end
		$display("test period update done");
	endtask : t_period
	task automatic t_rst();
		CLASS_B_FAULT_INPUT <= 1'b0;
		repeat (2) @(posedge CLK);
		check({31'h0, CLASS_B_FAULT_ACTIVE}, 32'h0);
		RESET <= 1'b1;
		repeat (2) @(posedge CLK);
		RESET <= 1'b0;
		check({31'h0, CLASS_B_FAULT_ACTIVE}, 32'h1);
		rd_reg(OFF_FLTCTL);
		check({30'h0, rd[1:0]}, {30'h0, FLT_MODE_LATCHED});
		rd_reg(OFF_TBCON);
		check(rd, {16'h0000, RST_TBCON});
		$display("test second reset done");
	endtask : t_rst
	task tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : tally_and_finish

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		{AWVALID, WVALID, BREADY, ARVALID, RREADY, CPU_IDLE} = 6'h00;
		{AWADDR, ARADDR, WDATA} = 48'h0;
		{sync_en, sync_inv} = 2'h0;
		REGISTER_LOCK_CONFIG = 1'b1;
		CLASS_B_FAULT_INPUT = 1'b1;
		RESET = 1'b1;
		repeat (2) @(posedge CLK);
		RESET <= 1'b0;
		t_reset();
		t_fault();
		t_lock();
		t_time();
		t_sync();
		t_period();
		t_rst();
		tally_and_finish();
	end
endmodule : tb_pwm_time_base_control
